//--- design/saps_pkg.sv
// Purpose: shared constants and types of the line protection switch block
// Assumes: 200 MHz clock, Avalon-MM register bus with byte addresses
// Notes:   request codes double as the transmitted request nibble
package saps_pkg;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_TIME_NS  = 1_000_000;
    localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WTR_TIME_MS   = 300_000;

    // -------------------------------------------------------------
    // thresholds, exponent n means ber of 10^-n
    // -------------------------------------------------------------
    localparam logic [3:0] SF_BER_EXP = 4'h3;
    localparam logic [3:0] SD_EXP_RST = 4'h6;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_CMD     = 8'h04;
    localparam logic [7:0] OFF_STATE   = 8'h08;
    localparam logic [7:0] OFF_ALARM   = 8'h0c;
    localparam logic [7:0] OFF_INT_ST  = 8'h10;
    localparam logic [7:0] OFF_INT_CLR = 8'h14;
    localparam logic [7:0] OFF_INT_EN  = 8'h18;

    localparam int CTRL_REVERT = 0;
    localparam int CTRL_BIDIR  = 1;
    localparam int CTRL_ARCH   = 2;
    localparam int CTRL_HIGH_PRIORITY_REQUEST  = 3;
    localparam int CTRL_SD_LSB = 4;
    localparam logic [7:0] CTRL_RST = {SD_EXP_RST, 4'h3};

    localparam int CMD_LOCKOUT = 0;
    localparam int CMD_FORCED  = 1;
    localparam int CMD_MANUAL  = 2;

    localparam int ST_SEL    = 0;
    localparam int ST_REQ    = 4;
    localparam int ST_WTR    = 8;
    localparam int ST_ARCH   = 9;
    localparam int ST_CHAN   = 10;
    localparam int ST_EVT    = 16;

    localparam int INT_SWITCH = 0;
    localparam int INT_FAIL   = 1;
    localparam int INT_SBY    = 2;
    localparam int INT_ARCH   = 3;
    localparam int INT_CHAN   = 4;
    localparam int INT_W      = 5;

    localparam int NUM_SBY = 12;
    localparam logic [2:0] K2_MODE_UNI   = 3'h4;
    localparam logic [2:0] K2_MODE_BIDIR = 3'h5;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        REQ_NR    = 4'h0,
        REQ_DNR   = 4'h1,
        REQ_RR    = 4'h2,
        REQ_WTR   = 4'h6,
        REQ_MS    = 4'h8,
        REQ_SD_LO = 4'ha,
        REQ_SD_HI = 4'hb,
        REQ_SF_LO = 4'hc,
        REQ_SF_HI = 4'hd,
        REQ_FS    = 4'he,
        REQ_LO    = 4'hf
    } saps_req_t;

    typedef enum logic [4:0] {
        EV_NONE      = 5'h00,
        EV_LOCKOUT   = 5'h01,
        EV_FORCED    = 5'h02,
        EV_SF_HI     = 5'h03,
        EV_SF_LO     = 5'h04,
        EV_SD_HI     = 5'h05,
        EV_SD_LO     = 5'h06,
        EV_MANUAL    = 5'h07,
        EV_WTR       = 5'h08,
        EV_REVERSE   = 5'h09,
        EV_NO_REVERT = 5'h0a,
        EV_CLEAR     = 5'h0b
    } saps_evt_code_t;
    localparam logic [4:0] EV_FAIL_BIT = 5'h10;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } saps_av_req_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] code;
    } saps_evt_t;

endpackage

//--- design/saps_sync.sv
// Purpose: three flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to i_clk
// Notes:   output changes once stages two and three agree
`timescale 1ns/100ps
module saps_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            o_q    <= '0;
        end else begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    o_q[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

//--- design/saps_tick.sv
// Purpose: divider giving a one-cycle enable pulse every N cycles
// Assumes: N of at least 2
// Notes:   used as the millisecond base of the restore wait timer
`timescale 1ns/100ps
module saps_tick #(
    parameter int N = 200000
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    output logic      o_tick
);
    localparam int CW = $clog2(N);
    localparam logic [CW-1:0] LAST = CW'(N - 1);

    logic [CW-1:0] cnt_reg;

    if (N < 2) begin : g_chk
        $error("saps_tick: N must be at least 2");
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= '0;
            o_tick  <= 1'b0;
        end else begin
            o_tick  <= (cnt_reg == LAST);
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end
endmodule

//--- design/saps_top.sv
// Purpose: protection switch decision and event reporting for a line pair
// Assumes: k-byte receiver and ber monitor run on i_clk; defects come from pins
// Notes:   one working and one protection line, registers over Avalon-MM
`timescale 1ns/100ps
module saps_top
    import saps_pkg::*;
#(
    parameter int TICK_CYC = saps_pkg::TICK_CYCLES,
    parameter int WTR_MS   = saps_pkg::WTR_TIME_MS
) (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // register bus
    input  wire saps_pkg::saps_av_req_t i_av,
    output logic [31:0]                o_av_readdata,
    output logic                       o_av_waitrequest,
    // line defects from pins: {ais_l, lof, los}
    input  wire logic [2:0]            i_wrk_defect,
    input  wire logic [2:0]            i_prt_defect,
    input  wire logic [saps_pkg::NUM_SBY-1:0] i_sby_defect,
    // ber exponents from the monitor
    input  wire logic [3:0]            i_wrk_ber_exp,
    input  wire logic [3:0]            i_prt_ber_exp,
    // k bytes
    input  wire logic [7:0]            i_rx_k1,
    input  wire logic [7:0]            i_rx_k2,
    input  wire logic                  i_k_valid,
    input  wire logic                  i_far_revertive,
    output logic [7:0]                 o_tx_k1,
    output logic [7:0]                 o_tx_k2,
    // switch, events and alarms
    output logic                       o_sel_prot,
    output saps_pkg::saps_evt_t        o_evt,
    output logic [saps_pkg::NUM_SBY-1:0] o_sby_alarm,
    output logic                       o_arch_mm,
    output logic                       o_chan_mm,
    output logic                       o_irq
);
    import saps_pkg::*;

    localparam int WW = $clog2(WTR_MS + 1);
    localparam logic [WW-1:0] WTR_LAST = WW'(WTR_MS - 1);

    if (WTR_MS < 1 || TICK_CYC < 2) begin : g_chk
        $error("saps_top: WTR_MS must be >= 1 and TICK_CYC >= 2");
    end

    // -------------------------------------------------------------
    // registers and wires
    // -------------------------------------------------------------
    logic [7:0]        ctrl_reg;
    logic [2:0]        cmd_reg;
    logic [INT_W-1:0]  int_reg;
    logic [INT_W-1:0]  int_next;
    logic [INT_W-1:0]  en_reg;
    logic              wait_reg;
    saps_req_t         req_reg;
    saps_req_t         req_next;
    logic              sel_next;
    logic [WW-1:0]     wtr_cnt_reg;
    logic              wtr_done_reg;
    logic [4:0]        last_evt_reg;

    logic [2:0]        wrk_def;
    logic [2:0]        prt_def;
    logic [NUM_SBY-1:0] sby_def;
    logic              ms_tick;

    // -------------------------------------------------------------
    // pin synchronisers and timer base
    // -------------------------------------------------------------
    saps_sync #(
        .W (6 + NUM_SBY)
    ) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_sby_defect, i_prt_defect, i_wrk_defect}),
        .o_q   ({sby_def, prt_def, wrk_def})
    );

    saps_tick #(
        .N (TICK_CYC)
    ) u_tick (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .o_tick (ms_tick)
    );

    // -------------------------------------------------------------
    // configuration fields
    // -------------------------------------------------------------
    wire       revertive = ctrl_reg[CTRL_REVERT];
    wire       bidir     = ctrl_reg[CTRL_BIDIR];
    wire       arch_1to1 = ctrl_reg[CTRL_ARCH];
    wire       hi_pri    = ctrl_reg[CTRL_HIGH_PRIORITY_REQUEST];
    wire [3:0] sd_exp    = ctrl_reg[CTRL_SD_LSB +: 4];

    // -------------------------------------------------------------
    // line condition
    // -------------------------------------------------------------
    // failure and degrade detect
    wire wrk_sf = (|wrk_def) || (i_wrk_ber_exp <= SF_BER_EXP);
    wire prt_sf = (|prt_def) || (i_prt_ber_exp <= SF_BER_EXP);
    wire wrk_sd = (i_wrk_ber_exp <= sd_exp);
    wire prt_sd = (i_prt_ber_exp <= sd_exp);

    wire saps_req_t sf_req = hi_pri ? REQ_SF_HI : REQ_SF_LO;
    wire saps_req_t sd_req = hi_pri ? REQ_SD_HI : REQ_SD_LO;

    wire far_sw = bidir && (i_rx_k1[3:0] == 4'h1) && (i_rx_k1[7:4] >= REQ_MS);

    // restore wait runs after a cleared automatic request
    wire auto_held = (req_reg == REQ_SF_HI) || (req_reg == REQ_SF_LO) ||
                     (req_reg == REQ_SD_HI) || (req_reg == REQ_SD_LO) ||
                     (req_reg == REQ_WTR);
    wire wtr_go    = revertive && o_sel_prot && auto_held && !wtr_done_reg;

    // -------------------------------------------------------------
    // request resolution
    // -------------------------------------------------------------
    // fixed priority order
    always_comb begin
        if (cmd_reg[CMD_LOCKOUT]) begin
            req_next = REQ_LO;
        end else if (cmd_reg[CMD_FORCED]) begin
            req_next = REQ_FS;
        end else if (wrk_sf) begin
            req_next = sf_req;
        end else if (wrk_sd) begin
            req_next = sd_req;
        end else if (cmd_reg[CMD_MANUAL]) begin
            req_next = REQ_MS;
        end else if (wtr_go) begin
            req_next = REQ_WTR;
        end else if (far_sw) begin
            req_next = REQ_RR;
        end else if (!revertive && o_sel_prot) begin
            req_next = REQ_DNR;
        end else begin
            req_next = REQ_NR;
        end
    end

    // -------------------------------------------------------------
    // target line and feasibility
    // -------------------------------------------------------------
    wire to_prot = (req_next == REQ_FS)    || (req_next == REQ_SF_HI) ||
                   (req_next == REQ_SF_LO) || (req_next == REQ_SD_HI) ||
                   (req_next == REQ_SD_LO) || (req_next == REQ_MS) ||
                   (req_next == REQ_RR);
    wire hold    = (req_next == REQ_WTR) || (req_next == REQ_DNR);
    wire want_prot = to_prot || (hold && o_sel_prot);

    // protection must be clean enough for the cause
    wire prt_bad = prt_sf || (prt_sd && (req_next != REQ_FS) &&
                   (req_next != REQ_SF_HI) && (req_next != REQ_SF_LO));
    // architecture mismatch blocks switching until valid k bytes clear it
    // lockout returns to working even under a mismatch
    wire can_sw  = (req_next == REQ_LO) || (!o_arch_mm && (want_prot ? !prt_bad : !wrk_sf));
    wire moving  = (want_prot != o_sel_prot);
    // failure when the switch is needed but refused
    wire sw_fail = moving && !can_sw;
    assign sel_next = (moving && can_sw) ? want_prot : o_sel_prot;

    // -------------------------------------------------------------
    // event coding
    // -------------------------------------------------------------
    logic [4:0] evt_base;
    always_comb begin
        case (req_next)
            REQ_LO:    evt_base = EV_LOCKOUT;
            REQ_FS:    evt_base = EV_FORCED;
            REQ_SF_HI: evt_base = EV_SF_HI;
            REQ_SF_LO: evt_base = EV_SF_LO;
            REQ_SD_HI: evt_base = EV_SD_HI;
            REQ_SD_LO: evt_base = EV_SD_LO;
            REQ_MS:    evt_base = EV_MANUAL;
            REQ_RR:    evt_base = EV_REVERSE;
            REQ_DNR:   evt_base = EV_NO_REVERT;
            // expiry of the wait is its own event
            REQ_NR:    evt_base = (req_reg == REQ_WTR) ? EV_WTR : EV_CLEAR;
            default:   evt_base = EV_NONE;
        endcase
    end

    // no exercise request, entering the wait is silent
    wire evt_fire = (req_next != req_reg) && (req_next != REQ_WTR);
    wire [4:0] evt_code = sw_fail ? (evt_base | EV_FAIL_BIT) : evt_base;

    // -------------------------------------------------------------
    // restore wait timer
    // -------------------------------------------------------------
    // count milliseconds while waiting
    wire wtr_exp = (req_reg == REQ_WTR) && ms_tick && (wtr_cnt_reg == WTR_LAST);

    always_ff @(posedge i_clk) begin
        if (i_rst || (req_reg != REQ_WTR)) begin
            wtr_cnt_reg <= '0;
        end else if (ms_tick) begin
            wtr_cnt_reg <= wtr_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wtr_done_reg <= 1'b0;
        end else if (wtr_exp) begin
            wtr_done_reg <= 1'b1;
        end else if (!auto_held) begin
            wtr_done_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // switch state, k bytes and events
    // -------------------------------------------------------------
    wire [2:0] k2_mode = bidir ? K2_MODE_BIDIR : K2_MODE_UNI;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            req_reg      <= REQ_NR;
            o_sel_prot   <= 1'b0;
            o_tx_k1      <= 8'h00;
            o_tx_k2      <= 8'h00;
            o_evt        <= '0;
            last_evt_reg <= 5'h00;
        end else begin
            req_reg      <= req_next;
            o_sel_prot   <= sel_next;
            o_tx_k1      <= {req_next, 3'h0, sel_next};
            o_tx_k2      <= {3'h0, sel_next, arch_1to1, k2_mode};
            o_evt.valid  <= evt_fire;
            o_evt.code   <= evt_fire ? evt_code : 5'h00;
            if (evt_fire) begin
                last_evt_reg <= evt_code;
            end
        end
    end

    // -------------------------------------------------------------
    // alarms
    // -------------------------------------------------------------
    wire       far_mode_ok = (i_rx_k2[2:0] == K2_MODE_UNI) ||
                             (i_rx_k2[2:0] == K2_MODE_BIDIR);
    wire       far_bidir   = (i_rx_k2[2:0] == K2_MODE_BIDIR);
    wire arch_diff = (i_rx_k2[3] != arch_1to1) || (far_bidir != bidir) ||
                     (i_far_revertive != revertive);
    wire chan_diff = bidir && (i_rx_k2[7:4] != o_tx_k1[3:0]);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_arch_mm   <= 1'b0;
            o_chan_mm   <= 1'b0;
            o_sby_alarm <= '0;
        end else begin
            o_sby_alarm <= sby_def;
            if (i_k_valid && far_mode_ok) begin
                o_arch_mm <= arch_diff;
            end
            if (i_k_valid) begin
                o_chan_mm <= chan_diff;
            end else if (!bidir) begin
                o_chan_mm <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // interrupt status
    // -------------------------------------------------------------
    wire sby_rise  = |(sby_def & ~o_sby_alarm);
    wire arch_rise = i_k_valid && far_mode_ok && arch_diff && !o_arch_mm;
    wire chan_rise = i_k_valid && chan_diff && !o_chan_mm;

    wire [INT_W-1:0] int_set = {chan_rise, arch_rise, sby_rise,
                                evt_fire && sw_fail, evt_fire && !sw_fail};

    // -------------------------------------------------------------
    // register bus
    // -------------------------------------------------------------
    wire       av_req  = i_av.read || i_av.write;
    wire       av_ans  = av_req && wait_reg;
    wire       wr_take = i_av.write && !wait_reg;
    wire [7:0] wa      = i_av.address;
    wire [31:0] wd     = i_av.writedata;

    wire wr_ctrl = wr_take && (wa == OFF_CTRL);
    wire wr_cmd  = wr_take && (wa == OFF_CMD);
    wire wr_clr  = wr_take && (wa == OFF_INT_CLR);
    wire wr_en   = wr_take && (wa == OFF_INT_EN);

    wire [INT_W-1:0] int_clr = wr_clr ? wd[INT_W-1:0] : '0;
    // set wins over a clear in the same cycle
    assign int_next = (int_reg & ~int_clr) | int_set;

    wire [31:0] st_word = {11'h000, last_evt_reg, 5'h00, o_chan_mm, o_arch_mm,
                           (req_reg == REQ_WTR), req_reg, 3'h0, o_sel_prot};

    wire [31:0] rd_mux =
        (wa == OFF_CTRL)   ? {24'h000000, ctrl_reg} :
        (wa == OFF_CMD)    ? {29'h00000000, cmd_reg} :
        (wa == OFF_STATE)  ? st_word :
        (wa == OFF_ALARM)  ? {20'h00000, o_sby_alarm} :
        (wa == OFF_INT_ST) ? {27'h0000000, int_reg} :
        (wa == OFF_INT_EN) ? {27'h0000000, en_reg} :
        32'h00000000;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wait_reg      <= 1'b1;
            o_av_readdata <= 32'h00000000;
        end else begin
            wait_reg      <= !av_ans;
            if (av_ans && i_av.read) begin
                o_av_readdata <= rd_mux;
            end
        end
    end

    assign o_av_waitrequest = wait_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_reg <= CTRL_RST;
            cmd_reg  <= 3'h0;
            en_reg   <= '0;
            int_reg  <= '0;
            o_irq    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wd[7:0];
            end
            if (wr_cmd) begin
                cmd_reg <= wd[2:0];
            end
            if (wr_en) begin
                en_reg <= wd[INT_W-1:0];
            end
            int_reg <= int_next;
            o_irq   <= |(int_next & (wr_en ? wd[INT_W-1:0] : en_reg));
        end
    end

endmodule

//--- test/saps_far_end.sv
// Purpose: far end protection controller model
// Assumes: shares the local clock
// Notes:   echoes the sent channel unless told to corrupt it
`timescale 1ns/100ps
module saps_far_end (
    // control
    input  wire logic       i_clk,
    input  wire logic       i_arch,
    input  wire logic       i_bidir,
    input  wire logic       i_rev,
    input  wire logic [3:0] i_req,
    input  wire logic       i_bad_chan,
    input  wire logic [7:0] i_tx_k1,
    // k bytes
    output logic [7:0]      o_k1,
    output logic [7:0]      o_k2,
    output logic            o_kv,
    output logic            o_rev
);
    assign o_k2 = {i_tx_k1[3:0] ^ {4{i_bad_chan}}, i_arch, 2'b10, i_bidir};
    always_ff @(posedge i_clk) begin
        o_k1  <= {i_req, 4'h1};
        o_kv  <= 1'b1;
        o_rev <= i_rev;
    end
endmodule

//--- test/saps_top_sva.sv
// Purpose: port assertions of the protection switch block
// Assumes: one clock, synchronous reset
// Notes:   bound onto saps_top
`timescale 1ns/100ps
module saps_top_sva
    import saps_pkg::*;
(
    // clock, reset and inputs
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire saps_pkg::saps_av_req_t i_av,
    input  wire logic [2:0]            i_wrk_defect,
    input  wire logic [11:0]           i_sby_defect,
    input  wire logic [7:0]            i_rx_k2,
    input  wire logic                  i_k_valid,
    input  wire logic                  i_far_revertive,
    // outputs
    input  wire logic [7:0]            o_tx_k1,
    input  wire logic [7:0]            o_tx_k2,
    input  wire logic                  o_sel_prot,
    input  wire saps_pkg::saps_evt_t   o_evt,
    input  wire logic [11:0]           o_sby_alarm,
    input  wire logic                  o_arch_mm,
    input  wire logic                  o_chan_mm
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_idle_code; !o_evt.valid |-> o_evt.code == 5'h00; endproperty
    a_idle_code: assert property (p_idle_code) else $error("code without strobe");
    property p_codes; o_evt.valid |-> o_evt.code[3:0] inside {[4'h1:4'hb]}; endproperty
    a_codes: assert property (p_codes) else $error("unknown event code");
    property p_lock; (o_tx_k1[7:4] == 4'hf)[*2] |-> !o_sel_prot; endproperty
    a_lock: assert property (p_lock) else $error("protection used in lockout");
    property p_sf; (i_wrk_defect != 3'h0)[*8] |-> o_tx_k1[7:4] >= 4'hc; endproperty
    a_sf: assert property (p_sf) else $error("no fail request");
    property p_sby; $stable(i_sby_defect)[*8] |-> o_sby_alarm == i_sby_defect; endproperty
    a_sby: assert property (p_sby) else $error("standby alarm wrong");
    property p_chan;
        (i_k_valid && o_tx_k2[2:0] == 3'h5 && i_rx_k2[7:4] != o_tx_k1[3:0])[*4] |-> o_chan_mm;
    endproperty
    a_chan: assert property (p_chan) else $error("channel mismatch missed");
    property p_arch;
        (i_k_valid && i_rx_k2[2:1] == 2'b10 && i_rx_k2[3] != o_tx_k2[3])[*4] |-> o_arch_mm;
    endproperty
    a_arch: assert property (p_arch) else $error("arch mismatch missed");
    property p_hold;
        o_arch_mm && !i_av.write && !$past(i_av.write) && $stable(i_rx_k2[3:0])
            && $stable(o_tx_k2[3:0]) && $stable(i_far_revertive) |=> o_arch_mm;
    endproperty
    a_hold: assert property (p_hold) else $error("arch mismatch dropped");
endmodule
bind saps_top saps_top_sva u_sva (.*);

//--- test/saps_top_test.sv
// Purpose: self-checking bench of the protection switch block
// Assumes: short tick and restore wait parameters
// Notes:   random defects and standby alarms from a fixed seed
`timescale 1ns/100ps
module saps_top_test;
    import saps_pkg::*;
    logic               clk, rst, wreq, irq, sel, amm, cmm, kv, frev;
    logic               f_arch, f_rev, f_bad;
    logic [2:0]         wrk, prt;
    logic [3:0]         wber, f_req;
    logic [7:0]         k1, k2, tk1, tk2;
    logic [11:0]        sby, sbyal;
    logic [31:0]        rdata, q;
    saps_av_req_t       av;
    saps_evt_t          evt;
    int                 err_count, total_checks, cycles;
    saps_top #(.TICK_CYC(10), .WTR_MS(3)) uut (
        .i_clk(clk), .i_rst(rst), .i_av(av), .o_av_readdata(rdata),
        .o_av_waitrequest(wreq), .i_wrk_defect(wrk), .i_prt_defect(prt),
        .i_sby_defect(sby), .i_wrk_ber_exp(wber), .i_prt_ber_exp(4'h9),
        .i_rx_k1(k1), .i_rx_k2(k2), .i_k_valid(kv), .i_far_revertive(frev),
        .o_tx_k1(tk1), .o_tx_k2(tk2), .o_sel_prot(sel), .o_evt(evt),
        .o_sby_alarm(sbyal), .o_arch_mm(amm), .o_chan_mm(cmm), .o_irq(irq));
    saps_far_end far (.i_clk(clk), .i_arch(f_arch), .i_bidir(1'b1), .i_rev(f_rev),
        .i_req(f_req), .i_bad_chan(f_bad), .i_tx_k1(tk1), .o_k1(k1), .o_k2(k2),
        .o_kv(kv), .o_rev(frev));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        av <= '{read: !wr, write: wr, address: a, writedata: d};
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        av <= '0;
    endtask
    task automatic exp_evt(input logic [4:0] c, input logic s);
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (evt.valid !== 1'b1 && n < 400);
        chk("event", {27'h0, c}, {27'h0, evt.code});
        cyc(2);
        chk("select", {31'h0, s}, {31'h0, sel});
    endtask
    function automatic logic [4:0] f_code(input logic hi, input logic sf);
        return 5'h3 + (sf ? 5'h0 : 5'h2) + (hi ? 5'h0 : 5'h1);
    endfunction
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        rst = 1'b1; av = '0; wrk = '0; prt = '0; sby = '0; wber = 4'h9;
        f_arch = 1'b0; f_rev = 1'b1; f_req = 4'h0; f_bad = 1'b0;
        void'($urandom(32'hdcf976b6));
        cyc(20);
        rst <= 1'b0;
        cyc(4);
        bus(1'b0, OFF_CTRL, 32'h0); chk("ctrl", {24'h0, CTRL_RST}, q);
        bus(1'b0, OFF_CMD, 32'h0); chk("cmd", 32'h0, q);
        bus(1'b0, 8'h1c, 32'h0); chk("unmapped", 32'h0, q);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFF_CTRL, {24'h0, 4'h6, i[0], 3'h3});
            if (i < 4) wber <= i[1] ? 4'h5 : 4'h3;
            else wrk <= 3'($urandom_range(7, 1));
            exp_evt(f_code(i[0], i[1] == 1'b0 || i == 4), 1'b1);
            wber <= 4'h9;
            wrk <= 3'h0;
            exp_evt(EV_WTR, 1'b0);
            $display("fail case %0d done", i);
        end
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b0, OFF_INT_ST, 32'h0); chk("status", 32'h1, q & 32'h1);
        bus(1'b1, OFF_INT_EN, 32'h1f); cyc(3); chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, OFF_INT_CLR, 32'h1f); cyc(3); chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, OFF_CMD, 32'h2); exp_evt(EV_FORCED, 1'b1);
        bus(1'b1, OFF_CMD, 32'h0); exp_evt(EV_CLEAR, 1'b0);
        f_rev <= 1'b0;
        bus(1'b1, OFF_CTRL, 32'h62);
        bus(1'b1, OFF_CMD, 32'h2); exp_evt(EV_FORCED, 1'b1);
        bus(1'b1, OFF_CMD, 32'h0); exp_evt(EV_NO_REVERT, 1'b1);
        bus(1'b1, OFF_CMD, 32'h1); exp_evt(EV_LOCKOUT, 1'b0);
        wrk <= 3'h1; cyc(12); chk("select", 32'h0, {31'h0, sel});
        wrk <= 3'h0; cyc(8); bus(1'b1, OFF_CMD, 32'h0); cyc(20);
        prt <= 3'h1; cyc(8); bus(1'b1, OFF_CMD, 32'h2);
        exp_evt(EV_FORCED | EV_FAIL_BIT, 1'b0);
        bus(1'b1, OFF_CMD, 32'h0); prt <= 3'h0; cyc(20);
        $display("user requests done");
        f_rev <= 1'b1;
        bus(1'b1, OFF_CTRL, 32'h63);
        f_req <= 4'hd; exp_evt(EV_REVERSE, 1'b1);
        f_req <= 4'h0; cyc(100);
        chk("k1", 32'h0, {24'h0, tk1});
        chk("k2", 32'h5, {24'h0, tk2});
        f_arch <= 1'b1; cyc(10); chk("arch", 32'h1, {31'h0, amm});
        cyc(20); chk("arch", 32'h1, {31'h0, amm});
        f_arch <= 1'b0; f_bad <= 1'b1; cyc(10); chk("chan", 32'h1, {31'h0, cmm});
        f_bad <= 1'b0; sby <= 12'($urandom); cyc(10);
        chk("standby", {20'h0, sby}, {20'h0, sbyal});
        $display("alarms done");
        end_of_test();
    end
endmodule
